//--- hdl/frame_stats.sv
// Pause-received and transmit-ok statistics counters with AHB-Lite slave.
// Assumes frame status strobes from MAC paths on hclk, one per frame end.
// Operation
// - A 16-bit counter counts good received pause frames.
// - A good received frame is 64 to 1518 bytes long by default.
// - With configuration bit 8 set the upper limit becomes 1536 bytes.
// - Frames with FCS, alignment or symbol errors are not counted.
// - A 24-bit counter counts successfully transmitted frames.
// - A transmit succeeds only without underrun and excess retries.
// - Reading a counter returns its value and clears it to zero, unless a write to it takes effect in that cycle.
// - A counter sticks at all ones until it is read or written.
// - Receive counters step only while receive enable is set.
// - Counter writes take effect only while control bit 7 is set.
`timescale 1ns/1ps
module frame_stats
   import stat_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic rx_frame_end,
   input wire logic rx_is_pause,
   input wire logic [13:0] rx_length,
   input wire logic rx_fcs_err,
   input wire logic rx_align_err,
   input wire logic rx_symbol_err,
   input wire logic tx_frame_end,
   input wire logic tx_underrun,
   input wire logic tx_retry_exceeded
);
   import stat_pkg::*;

   logic [31:0] net_ctrl_r;
   logic [31:0] net_cfg_r;
   logic wr_pend_r;
   logic [7:0] addr_r;
   logic [31:0] hrdata_r;
   logic rx_good_nxt;
   logic tx_good_nxt;
   logic pause_inc_r;
   logic tx_inc_r;
   logic [13:0] len_max;
   logic rd_pause;
   logic rd_tx;
   logic wr_stat;
   logic wr_pause;
   logic wr_tx;
   logic rd_take;
   logic [PAUSE_CNT_W-1:0] pause_cnt;
   logic [TX_CNT_W-1:0] tx_cnt;

   // Assertions below share this clock and reset
   default clocking cb_hclk @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_r;

   assign rd_take = hsel && hready && htrans[1] && !hwrite;
   assign rd_pause = rd_take && haddr[7:0] == OFS_PAUSE_RX;
   assign rd_tx = rd_take && haddr[7:0] == OFS_TX_OK;
   assign wr_stat = wr_pend_r && net_ctrl_r[CTRL_STAT_WR_BIT];
   assign wr_pause = wr_stat && addr_r == OFS_PAUSE_RX;
   assign wr_tx = wr_stat && addr_r == OFS_TX_OK;

   // Upper length limit by configuration
   always_comb
   begin
      if (net_cfg_r[CFG_BIG_FRAME_BIT])
         len_max = LEN_MAX_BIG;
      else
         len_max = LEN_MAX;
   end

   // Frame qualification
   always_comb
   begin
      rx_good_nxt = rx_frame_end && rx_is_pause
         && rx_length >= LEN_MIN && rx_length <= len_max
         && !rx_fcs_err && !rx_align_err && !rx_symbol_err
         && net_ctrl_r[CTRL_RX_EN_BIT];
      tx_good_nxt = tx_frame_end && !tx_underrun
         && !tx_retry_exceeded;
   end

   // Registered increment strobes
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pause_inc_r <= 1'b0;
         tx_inc_r <= 1'b0;
      end
      else
      begin
         pause_inc_r <= rx_good_nxt;
         tx_inc_r <= tx_good_nxt;
      end
   end

   // Write address phase capture
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_r <= 1'b0;
         addr_r <= 8'h00;
      end
      else if (hready)
      begin
         wr_pend_r <= hsel && htrans[1] && hwrite;
         addr_r <= haddr[7:0];
      end
   end

   // Control and configuration registers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         net_ctrl_r <= NET_CTRL_RESET;
         net_cfg_r <= NET_CFG_RESET;
      end
      else if (wr_pend_r)
      begin
         if (addr_r == OFS_NET_CTRL)
            net_ctrl_r <= hwdata;
         else if (addr_r == OFS_NET_CFG)
            net_cfg_r <= hwdata;
      end
   end

   // Read data, latched at address phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata_r <= 32'h00000000;
      else if (rd_take)
      begin
         if (haddr[7:0] == OFS_PAUSE_RX)
            hrdata_r <= {{(32-PAUSE_CNT_W){1'b0}}, pause_cnt};
         else if (haddr[7:0] == OFS_TX_OK)
            hrdata_r <= {{(32-TX_CNT_W){1'b0}}, tx_cnt};
         else if (haddr[7:0] == OFS_NET_CTRL)
            hrdata_r <= net_ctrl_r;
         else if (haddr[7:0] == OFS_NET_CFG)
            hrdata_r <= net_cfg_r;
         else
            hrdata_r <= 32'h00000000;
      end
   end

   sat_counter #(.WIDTH(PAUSE_CNT_W)) u_pause
   (
      .hclk(hclk),
      .hresetn(hresetn),
      .inc(pause_inc_r),
      .clr(rd_pause),
      .load(wr_pause),
      .load_val(hwdata[PAUSE_CNT_W-1:0]),
      .count(pause_cnt)
   );

   sat_counter #(.WIDTH(TX_CNT_W)) u_tx
   (
      .hclk(hclk),
      .hresetn(hresetn),
      .inc(tx_inc_r),
      .clr(rd_tx),
      .load(wr_tx),
      .load_val(hwdata[TX_CNT_W-1:0]),
      .count(tx_cnt)
   );

   sequence s_pause_good;
      rx_frame_end && rx_is_pause && rx_length >= LEN_MIN
         && rx_length <= len_max && !rx_fcs_err && !rx_align_err
         && !rx_symbol_err && net_ctrl_r[CTRL_RX_EN_BIT];
   endsequence

   sequence s_idle_step;
      !rd_pause && !wr_pause && pause_cnt != 16'hFFFF;
   endsequence

   AST_PAUSE_COUNT: assert property (
      s_pause_good ##1 s_idle_step |=> pause_cnt == $past(pause_cnt) + 1'b1)
      else $error("good pause frame not counted");
   AST_LEN_LOW: assert property (
      rx_frame_end && rx_length < LEN_MIN |=> !pause_inc_r)
      else $error("short frame counted");
   AST_LEN_HIGH: assert property (
      rx_frame_end && !net_cfg_r[CFG_BIG_FRAME_BIT] && rx_length > LEN_MAX
      |=> !pause_inc_r)
      else $error("long frame counted");
   AST_LEN_BIG: assert property (
      rx_frame_end && rx_length > LEN_MAX_BIG |=> !pause_inc_r)
      else $error("oversized frame counted");
   AST_RX_ERR: assert property (
      (rx_fcs_err || rx_align_err || rx_symbol_err) |=> !pause_inc_r)
      else $error("errored frame counted");
   AST_TX_OK: assert property (
      tx_frame_end && !tx_underrun && !tx_retry_exceeded ##1
      (!rd_tx && !wr_tx && tx_cnt != 24'hFFFFFF)
      |=> tx_cnt == $past(tx_cnt) + 1'b1)
      else $error("good transmit not counted");
   AST_TX_BAD: assert property (
      (tx_underrun || tx_retry_exceeded) |=> !tx_inc_r)
      else $error("failed transmit counted");
   AST_READ_CLR: assert property (
      rd_tx && !wr_tx |=> tx_cnt == 24'h000000
      && hrdata_r[23:0] == $past(tx_cnt))
      else $error("read did not return and clear");
   AST_RX_EN: assert property (
      !net_ctrl_r[CTRL_RX_EN_BIT] |=> !pause_inc_r)
      else $error("rx counted while disabled");
   AST_WR_GATE: assert property (
      wr_pend_r && addr_r == OFS_TX_OK && !net_ctrl_r[CTRL_STAT_WR_BIT]
      && !tx_inc_r && !rd_tx |=> tx_cnt == $past(tx_cnt))
      else $error("gated write took effect");
   AST_ONCE: assert property (
      !tx_frame_end |=> !tx_inc_r)
      else $error("count without frame end");
endmodule

//--- hdl/stat_pkg.sv
// Constants for the frame statistics counter block.
// Assumes a 32-bit AHB-Lite register bus and a single clock.
package stat_pkg;
   localparam logic [7:0] OFS_PAUSE_RX = 8'h00;
   localparam logic [7:0] OFS_TX_OK = 8'h04;
   localparam logic [7:0] OFS_NET_CTRL = 8'h08;
   localparam logic [7:0] OFS_NET_CFG = 8'h0C;
   localparam int CTRL_RX_EN_BIT = 2;
   localparam int CTRL_STAT_WR_BIT = 7;
   localparam int CFG_BIG_FRAME_BIT = 8;
   localparam logic [31:0] NET_CTRL_RESET = 32'h00000000;
   localparam logic [31:0] NET_CFG_RESET = 32'h00000000;
   localparam int PAUSE_CNT_W = 16;
   localparam int TX_CNT_W = 24;
   localparam logic [13:0] LEN_MIN = 14'h0040;
   localparam logic [13:0] LEN_MAX = 14'h05EE;
   localparam logic [13:0] LEN_MAX_BIG = 14'h0600;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

//--- hdl/sat_counter.sv
// Saturating counter that clears on a read and loads on a write.
// Assumes single-cycle inc, clr and load strobes from the same clock.
`timescale 1ns/1ps
module sat_counter
#(
   parameter int WIDTH = 16
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic inc,
   input wire logic clr,
   input wire logic load,
   input wire logic [WIDTH-1:0] load_val,
   output logic [WIDTH-1:0] count
);
   logic [WIDTH-1:0] count_r;
   assign count = count_r;

   // Load wins, then read clear, then a saturating step
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         count_r <= '0;
      else if (load)
         count_r <= load_val;
      else if (clr)
         count_r <= '0;
      else if (inc && count_r != {WIDTH{1'b1}})
         count_r <= count_r + 1'b1;
   end

   AST_SAT_HOLD: assert property (
      @(posedge hclk) disable iff (!hresetn)
      count_r == {WIDTH{1'b1}} && !clr && !load |=> count_r == $past(count_r))
      else $error("counter left saturation without read");
endmodule

//--- testbench/mac_status_model.sv
// Behavioural model of the MAC receive and transmit status paths.
// Assumes its tasks are called right after a rising hclk edge.
`timescale 1ns/1ps
module mac_status_model
(
   input wire logic hclk,
   output logic rx_frame_end,
   output logic rx_is_pause,
   output logic [13:0] rx_length,
   output logic [2:0] rx_err,
   output logic tx_frame_end,
   output logic [1:0] tx_fail
);
   initial
   begin
      rx_frame_end = 1'b0;
      rx_is_pause = 1'b0;
      rx_length = 14'h0000;
      rx_err = 3'h0;
      tx_frame_end = 1'b0;
      tx_fail = 2'h0;
   end
   // One frame end per cycle; status valid only with the pulse
   task automatic rx(input logic p, input logic [13:0] n,
      input logic [2:0] e);
      rx_frame_end <= 1'b1;
      tx_frame_end <= 1'b0;
      rx_is_pause <= p;
      rx_length <= n;
      rx_err <= e;
      @(posedge hclk);
   endtask
   task automatic tx(input logic [1:0] f);
      tx_frame_end <= 1'b1;
      rx_frame_end <= 1'b0;
      tx_fail <= f;
      @(posedge hclk);
   endtask
   // Outside frames the status lines carry no stale value
   task automatic idle();
      rx_frame_end <= 1'b0;
      tx_frame_end <= 1'b0;
      rx_is_pause <= ~rx_is_pause;
      rx_length <= ~rx_length;
      rx_err <= ~rx_err;
      tx_fail <= ~tx_fail;
      repeat (3) @(posedge hclk);
   endtask
endmodule

//--- testbench/test_frame_stats.sv
// Self-checking bench for frame_stats over AHB-Lite.
// Assumes one AHB-Lite slave; every wait for hready is bounded.
`timescale 1ns/1ps
module test_frame_stats;
   import stat_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout, hresp, dp_rd = 1'b0;
   logic rfe, rp, tfe;
   logic [13:0] rl;
   logic [2:0] re;
   logic [1:0] tf;
   logic [1:0] tfv;
   logic [31:0] q[$];
   int err_total = 0;
   int n_checks = 0;
   int nt;
   always #5 hclk = ~hclk;
   mac_status_model mdl (.hclk(hclk), .rx_frame_end(rfe),
      .rx_is_pause(rp), .rx_length(rl), .rx_err(re),
      .tx_frame_end(tfe), .tx_fail(tf));
   frame_stats uut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .rx_frame_end(rfe), .rx_is_pause(rp), .rx_length(rl),
      .rx_fcs_err(re[0]), .rx_align_err(re[1]),
      .rx_symbol_err(re[2]), .tx_frame_end(tfe),
      .tx_underrun(tf[0]), .tx_retry_exceeded(tf[1]));
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] v,
      input logic [31:0] e);
      n_checks++;
      if (v !== e)
      begin
         err_total++;
         $display("CHECK FAILED %s exp %h seen %h", s, e, v);
      end
   endtask
   task automatic wt();
      int n;
      n = 0;
      do
      begin
         @(posedge hclk);
         n++;
      end
      while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1)
      begin
         err_total++;
         finish_test();
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      htrans <= HTRANS_NONSEQ;
      haddr <= {24'h0, a};
      hwrite <= w;
      wt();
      htrans <= 2'h0;
      hwdata <= d;
      dp_rd <= !w;
      wt();
      dp_rd <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      q.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask
   always @(posedge hclk)
   begin
      if (dp_rd && q.size() > 0)
         chk("hrdata", hrdata, q.pop_front());
      if (dp_rd)
         chk("hresp", 32'(hresp), 32'h0);
   end
   initial
   begin
      #300000;
      err_total++;
      finish_test();
   end
   initial
   begin
      void'($urandom(28492));
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int i = 0; i < 5; i++)
         rd(8'(i * 4), 32'h0);
      bus(1'b1, OFS_NET_CTRL, 32'h00000004);
      mdl.rx(1'b1, 14'd64, 3'h0);
      mdl.rx(1'b1, 14'd1518, 3'h0);
      mdl.rx(1'b1, 14'd63, 3'h0);
      mdl.rx(1'b1, 14'd1519, 3'h0);
      mdl.rx(1'b0, 14'd100, 3'h0);
      for (int i = 0; i < 3; i++)
         mdl.rx(1'b1, 14'd100, 3'(1 << i));
      mdl.idle();
      rd(OFS_PAUSE_RX, 32'h2);
      rd(OFS_PAUSE_RX, 32'h0);
      bus(1'b1, OFS_NET_CFG, 32'h00000100);
      mdl.rx(1'b1, 14'd1536, 3'h0);
      mdl.rx(1'b1, 14'd1537, 3'h0);
      mdl.idle();
      rd(OFS_PAUSE_RX, 32'h1);
      bus(1'b1, OFS_NET_CTRL, 32'h0);
      mdl.rx(1'b1, 14'd64, 3'h0);
      mdl.idle();
      rd(OFS_PAUSE_RX, 32'h0);
      nt = 0;
      for (int i = 0; i < 20; i++)
      begin
         tfv = 2'($urandom);
         if (tfv == 2'h0)
            nt++;
         mdl.tx(tfv);
      end
      mdl.idle();
      rd(OFS_TX_OK, 32'(nt));
      bus(1'b1, OFS_TX_OK, 32'h00001234);
      rd(OFS_TX_OK, 32'h0);
      bus(1'b1, OFS_NET_CTRL, 32'h00000084);
      bus(1'b1, OFS_TX_OK, 32'h00FFFFFF);
      bus(1'b1, OFS_PAUSE_RX, 32'h0000FFFF);
      mdl.rx(1'b1, 14'd64, 3'h0);
      mdl.tx(2'h0);
      mdl.idle();
      rd(OFS_TX_OK, 32'h00FFFFFF);
      rd(OFS_PAUSE_RX, 32'h0000FFFF);
      rd(OFS_PAUSE_RX, 32'h0);
      finish_test();
   end
endmodule
